/* hdl/vio_pkg.sv */
`default_nettype none
package vio_pkg;
    // clock and time bases
    localparam int unsigned CLK_PERIOD_NS = 10;                   // 100 MHz system clock
    localparam int unsigned US_NS         = 1000;                 // one microsecond
    localparam int unsigned MS_US         = 1000;                 // one millisecond in us
    localparam int unsigned US_CYC        = US_NS / CLK_PERIOD_NS; // cycles per microsecond
    localparam int unsigned MS_CYC        = MS_US * US_CYC;        // cycles per millisecond
    localparam int unsigned BTN_HOLD_MS   = 2000;                 // front-panel reset hold
    // pulse and watchdog limits
    localparam logic [31:0] US_MIN        = 32'h0000000A;         // least delay/width in us
    localparam logic [15:0] WD_MAX_MS     = 16'hFFFE;             // longest watchdog timeout
    // counts of things
    localparam int unsigned N_PG          = 6;                    // pulse generators
    localparam int unsigned N_ISO_IN      = 12;
    localparam int unsigned N_TTL_IN      = 2;
    localparam int unsigned N_TTL_OUT     = 10;                   // wd, 3 gp, 6 pulse
    localparam int unsigned N_ISO_OUT     = 4;
    localparam int unsigned N_PIN         = 17;                   // iso, ttl, safe, heat, button
    // bit positions in the synchronised pin vector
    localparam int unsigned PIN_PSEL0     = 0;                    // iso 0..4 product data
    localparam int unsigned PIN_LATCH     = 5;
    localparam int unsigned PIN_ENC_A     = 6;
    localparam int unsigned PIN_ENC_B     = 7;
    localparam int unsigned PIN_TRIG8     = 8;
    localparam int unsigned PIN_GP0       = 9;                    // iso 9 and 10
    localparam int unsigned PIN_SHDN      = 11;
    localparam int unsigned PIN_TTL0      = 12;
    localparam int unsigned PIN_TTL1      = 13;
    localparam int unsigned PIN_SAFE      = 14;
    localparam int unsigned PIN_HEAT      = 15;
    localparam int unsigned PIN_BTN       = 16;
    // bit positions in the ttl output vector
    localparam int unsigned TTL_WD        = 0;
    localparam int unsigned TTL_GP0       = 1;
    localparam int unsigned TTL_PG0       = 4;

    typedef enum logic [2:0] {
        VIO_TRIG_IMM, VIO_TRIG_TTL0, VIO_TRIG_TTL1, VIO_TRIG_ISO5, VIO_TRIG_ISO8
    } vio_trig_e;

    typedef enum logic [1:0] {
        VIO_WD_IND, VIO_WD_TTL, VIO_WD_SHDN
    } vio_wd_act_e;

    typedef enum logic [1:0] {
        VIO_FS_LOW, VIO_FS_HIGH, VIO_FS_HIZ
    } vio_fs_e;

    typedef enum logic [1:0] {
        VIO_PG_IDLE, VIO_PG_ARM, VIO_PG_DELAY, VIO_PG_ACTIVE
    } vio_pg_st_e;

    typedef struct packed {
        logic        run;        // start (1) or stop (0)
        vio_trig_e   trig;       // start source
        logic        edge_fall;  // trigger on falling edge
        logic        act_high;   // output polarity
        logic        delay_enc;  // delay in encoder counts
        logic [31:0] delay;
        logic [31:0] width;      // always microseconds
    } vio_pg_cfg_s;

    typedef struct packed {
        logic        arm;        // watchdog armed
        logic        kick;       // software service pulse
        vio_wd_act_e act;
        logic [15:0] timeout_ms;
    } vio_wd_cfg_s;
endpackage
`default_nettype wire

/* hdl/vio_top.sv */
// Overview of operation
// - width in microseconds, ten and up
// - each generator picks its own trigger edge
// - encoder phases on iso six, seven
// - count every phase edge, 100 kHz inputs
// - delay may advance on encoder counts
// - five product inputs sampled together
// - iso five rising edge latches product
// - general inputs never trigger generators
// - software reads inputs, drives outputs unless forced
// - three faults: shutdown, watchdog, overheat
// - safe off, shutdown on: halt, force
// - shutdown off: external ignored, others halt
// - safe on: never force, overheat halts
// - iso eleven inactive flags external shutdown
// - halt persists until device reset
// - per-output fault states for ttl, iso
// - shutdown enable cleared only by reset
// - watchdog counts milliseconds up to 65534
// - indicator flag holds until disarm; resets io
// - output action drives ttl zero high
// - shutdown action halts unless safe on, lights fault
// - assert after delay, deassert after width
// - trigger: one per edge; immediate repeats
// - delay in 32-bit counter, both units
`default_nettype none
module vio_top #(
    parameter int unsigned MS_CYC = vio_pkg::MS_CYC  // cycles per millisecond
) (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              resetn,
    // field pins and switches
    input  wire logic [vio_pkg::N_ISO_IN-1:0]      iso_in,
    input  wire logic [vio_pkg::N_TTL_IN-1:0]      ttl_in,
    input  wire logic                              safe_sw,
    input  wire logic                              overheat,
    input  wire logic                              reset_btn,
    // software configuration
    input  vio_pkg::vio_pg_cfg_s [vio_pkg::N_PG-1:0] pg_cfg,
    input  vio_pkg::vio_wd_cfg_s                   wd_cfg,
    input  wire logic                              shdn_en_cfg,
    input  wire logic                              psel_latch_en,
    input  wire logic [2:0]                        gp_ttl_set,
    input  wire logic [vio_pkg::N_ISO_OUT-1:0]     gp_iso_set,
    input  vio_pkg::vio_fs_e [vio_pkg::N_TTL_OUT-1:0] fs_ttl,
    input  wire logic [vio_pkg::N_ISO_OUT-1:0]     fs_iso,
    // outputs to field
    output logic [vio_pkg::N_TTL_OUT-1:0]          ttl_out,
    output logic [vio_pkg::N_TTL_OUT-1:0]          ttl_oe,
    output logic [vio_pkg::N_ISO_OUT-1:0]          iso_out,
    // status to software and panel
    output logic [31:0]                            enc_count,
    output logic [4:0]                             psel_value,
    output logic [1:0]                             gp_in,
    output logic                                   wd_expired,
    output logic                                   halted,
    output logic                                   power_fault,
    output logic                                   outputs_forced,
    output logic                                   sys_reset_req
);
    localparam logic [6:0]  US_LAST  = 7'(vio_pkg::US_CYC - 1);
    localparam logic [16:0] MS_LAST  = 17'(MS_CYC - 1);
    localparam logic [11:0] BTN_LAST = 12'(vio_pkg::BTN_HOLD_MS - 1);
    localparam logic [16:0] PIN_IDLE = 17'(32'h00000001 << vio_pkg::PIN_SHDN);  // shutdown pin rests high

    // raw pins gathered for synchronising
    logic [vio_pkg::N_PIN-1:0] pin_raw;
    logic [vio_pkg::N_PIN-1:0] s1_r, s2_r, s3_r;  // three-stage synchroniser
    logic [vio_pkg::N_PIN-1:0] sig_r;             // accepted level
    logic [vio_pkg::N_PIN-1:0] prev_r;            // level one cycle ago
    logic [vio_pkg::N_PIN-1:0] rise, fall;

    assign pin_raw = {reset_btn, overheat, safe_sw, ttl_in, iso_in};

    // per-pin synchroniser; accept a level once stages two and three agree
    for (genvar p = 0; p < vio_pkg::N_PIN; p++) begin : g_sync
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                s1_r[p]   <= PIN_IDLE[p];
                s2_r[p]   <= PIN_IDLE[p];
                s3_r[p]   <= PIN_IDLE[p];
                sig_r[p]  <= PIN_IDLE[p];  // no false shutdown after reset
                prev_r[p] <= PIN_IDLE[p];
            end else begin
                s1_r[p]   <= pin_raw[p];
                s2_r[p]   <= s1_r[p];
                s3_r[p]   <= s2_r[p];
                sig_r[p]  <= (s2_r[p] == s3_r[p]) ? s3_r[p] : sig_r[p];
                prev_r[p] <= sig_r[p];
            end
        end
    end

    assign rise = sig_r & ~prev_r;
    assign fall = ~sig_r & prev_r;

    // shared millisecond tick; microsecond ticks per generator
    logic [16:0] ms_pre_r;
    logic        ms_tick;
    assign ms_tick = (ms_pre_r == MS_LAST);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ms_pre_r <= '0;
        end else begin
            ms_pre_r <= ms_tick ? '0 : ms_pre_r + 17'h00001;
        end
    end

    // quadrature decode on synchronised phases
    logic [1:0]  enc_now, enc_old;
    logic        enc_step, enc_up;
    logic [31:0] enc_cnt_r;
    assign enc_now  = {sig_r[vio_pkg::PIN_ENC_A], sig_r[vio_pkg::PIN_ENC_B]};
    assign enc_old  = {prev_r[vio_pkg::PIN_ENC_A], prev_r[vio_pkg::PIN_ENC_B]};
    assign enc_step = (enc_now != enc_old) && (enc_now != ~enc_old);
    // a leads b: up
    assign enc_up   = enc_now[1] ^ enc_old[0];

    // signed position, every phase edge counted
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enc_cnt_r <= '0;
        end else if (enc_step) begin
            enc_cnt_r <= enc_up ? enc_cnt_r + 32'h00000001 : enc_cnt_r - 32'h00000001;
        end
    end
    assign enc_count = enc_cnt_r;

    // product select: live or latched on iso five rising edge
    logic [4:0] psel_live;
    logic [4:0] psel_r;
    assign psel_live = sig_r[vio_pkg::PIN_PSEL0 +: 5];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            psel_r <= '0;
        end else if (!psel_latch_en || rise[vio_pkg::PIN_LATCH]) begin
            psel_r <= psel_live;
        end
    end
    assign psel_value = psel_r;

    // general inputs read only here, never by generators
    assign gp_in = sig_r[vio_pkg::PIN_GP0 +: 2];

    // shutdown enable sticks until reset
    logic shdn_en_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shdn_en_r <= 1'b0;
        end else if (shdn_en_cfg) begin
            shdn_en_r <= 1'b1;
        end
    end

    // watchdog
    logic [15:0] wd_cnt_r;
    logic        wd_exp_r;
    logic        wd_arm_d_r;
    logic [15:0] wd_limit;
    logic        wd_disarm;
    assign wd_limit  = (wd_cfg.timeout_ms > vio_pkg::WD_MAX_MS) ? vio_pkg::WD_MAX_MS : wd_cfg.timeout_ms;
    assign wd_disarm = wd_arm_d_r && !wd_cfg.arm;

    // millisecond count; expiry sticks until disarmed
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_r   <= '0;
            wd_exp_r   <= 1'b0;
            wd_arm_d_r <= 1'b0;
        end else begin
            wd_arm_d_r <= wd_cfg.arm;
            if (!wd_cfg.arm) begin
                wd_cnt_r <= '0;
                wd_exp_r <= 1'b0;
            end else if (wd_cfg.kick && !wd_exp_r) begin
                wd_cnt_r <= '0;
            end else if (ms_tick && !wd_exp_r) begin
                wd_cnt_r <= wd_cnt_r + 16'h0001;
                wd_exp_r <= (wd_cnt_r + 16'h0001) >= wd_limit;
            end
        end
    end
    assign wd_expired = wd_exp_r;

    // fault sources and responses
    logic safe_on, f_ext, f_wd, f_heat, halt_now, force_now;
    logic halt_r, force_r;
    assign safe_on   = sig_r[vio_pkg::PIN_SAFE];
    assign f_ext     = shdn_en_r && !safe_on && !sig_r[vio_pkg::PIN_SHDN];
    assign f_wd      = wd_exp_r && (wd_cfg.act == vio_pkg::VIO_WD_SHDN);
    assign f_heat    = sig_r[vio_pkg::PIN_HEAT];
    assign halt_now  = f_ext || (f_wd && !safe_on) || f_heat;
    assign force_now = halt_now && shdn_en_r && !safe_on;

    // faults latch until reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            halt_r  <= 1'b0;
            force_r <= 1'b0;
        end else begin
            halt_r  <= halt_r || halt_now;
            force_r <= force_r || force_now;
        end
    end
    assign halted         = halt_r;
    assign power_fault    = halt_r;
    assign outputs_forced = force_r;

    // button held two seconds requests reset
    logic [11:0] btn_ms_r;
    logic        btn_req_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            btn_ms_r  <= '0;
            btn_req_r <= 1'b0;
        end else begin
            btn_req_r <= 1'b0;
            if (!sig_r[vio_pkg::PIN_BTN]) begin
                btn_ms_r <= '0;
            end else if (ms_tick && btn_ms_r != BTN_LAST) begin
                btn_ms_r <= btn_ms_r + 12'h001;
            end else if (ms_tick) begin
                btn_req_r <= 1'b1;
            end
        end
    end
    assign sys_reset_req = btn_req_r;

    // trigger edges; general inputs excluded
    logic [3:0] trig_rise, trig_fall;
    assign trig_rise = {rise[vio_pkg::PIN_TRIG8], rise[vio_pkg::PIN_LATCH],
                        rise[vio_pkg::PIN_TTL1], rise[vio_pkg::PIN_TTL0]};
    assign trig_fall = {fall[vio_pkg::PIN_TRIG8], fall[vio_pkg::PIN_LATCH],
                        fall[vio_pkg::PIN_TTL1], fall[vio_pkg::PIN_TTL0]};

    // pulse generators
    logic [vio_pkg::N_PG-1:0] pg_out;
    logic                     pg_stop_all;
    assign pg_stop_all = halt_r || wd_disarm;

    for (genvar g = 0; g < vio_pkg::N_PG; g++) begin : g_pg
        vio_pkg::vio_pg_cfg_s cfg_r;    // frozen while running
        vio_pkg::vio_pg_st_e  st_r;
        logic [31:0]          cnt_r;    // remaining delay or width
        logic [6:0]           pre_r;    // microsecond prescaler
        logic                 us_tick;
        logic                 edge_hit;
        logic [3:0]           edges;
        logic [31:0]          delay_ld;
        logic [31:0]          width_ld;
        logic [1:0]           src;

        assign us_tick  = (pre_r == US_LAST);
        assign edges    = cfg_r.edge_fall ? trig_fall : trig_rise;
        assign src      = 2'(cfg_r.trig - vio_pkg::VIO_TRIG_TTL0);
        assign edge_hit = (cfg_r.trig != vio_pkg::VIO_TRIG_IMM) && edges[src];
        assign delay_ld = (cfg_r.delay_enc || cfg_r.delay >= vio_pkg::US_MIN) ? cfg_r.delay : vio_pkg::US_MIN;
        assign width_ld = (cfg_r.width < vio_pkg::US_MIN) ? vio_pkg::US_MIN : cfg_r.width;

        // generator sequence: idle, armed, delay, active
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                st_r  <= vio_pkg::VIO_PG_IDLE;
                cfg_r <= '0;
                cnt_r <= '0;
                pre_r <= '0;
            end else begin
                pre_r <= us_tick ? '0 : pre_r + 7'h01;
                if (!pg_cfg[g].run || pg_stop_all) begin
                    st_r <= vio_pkg::VIO_PG_IDLE;
                end else begin
                    case (st_r)
                        vio_pkg::VIO_PG_IDLE: begin
                            cfg_r <= pg_cfg[g];
                            st_r  <= vio_pkg::VIO_PG_ARM;
                        end
                        vio_pkg::VIO_PG_ARM: begin
                            // wait for the selected edge, or go at once
                            if (cfg_r.trig == vio_pkg::VIO_TRIG_IMM || edge_hit) begin
                                st_r  <= vio_pkg::VIO_PG_DELAY;
                                cnt_r <= delay_ld;
                                pre_r <= '0;
                            end
                        end
                        vio_pkg::VIO_PG_DELAY: begin
                            // delay in encoder counts or microseconds
                            if (cfg_r.delay_enc && cnt_r == '0) begin
                                st_r  <= vio_pkg::VIO_PG_ACTIVE;
                                cnt_r <= width_ld;
                                pre_r <= '0;
                            end else if (cfg_r.delay_enc) begin
                                cnt_r <= enc_step ? cnt_r - 32'h00000001 : cnt_r;
                            end else if (us_tick && cnt_r == 32'h00000001) begin
                                st_r  <= vio_pkg::VIO_PG_ACTIVE;
                                cnt_r <= width_ld;
                            end else if (us_tick) begin
                                cnt_r <= cnt_r - 32'h00000001;
                            end
                        end
                        vio_pkg::VIO_PG_ACTIVE: begin
                            // width always in microseconds
                            if (us_tick && cnt_r == 32'h00000001) begin
                                if (cfg_r.trig == vio_pkg::VIO_TRIG_IMM) begin
                                    st_r  <= vio_pkg::VIO_PG_DELAY;
                                    cnt_r <= delay_ld;
                                end else begin
                                    st_r  <= vio_pkg::VIO_PG_ARM;
                                end
                            end else if (us_tick) begin
                                cnt_r <= cnt_r - 32'h00000001;
                            end
                        end
                        default: begin
                            st_r <= vio_pkg::VIO_PG_IDLE;
                        end
                    endcase
                end
            end
        end

        // output level by polarity
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                pg_out[g] <= 1'b0;
            end else begin
                pg_out[g] <= (st_r == vio_pkg::VIO_PG_ACTIVE) ~^ cfg_r.act_high;
            end
        end
    end

    // normal output drive before fault override
    logic [vio_pkg::N_TTL_OUT-1:0] ttl_norm;
    logic                          wd_pin;
    assign wd_pin   = wd_exp_r && (wd_cfg.act == vio_pkg::VIO_WD_TTL);
    assign ttl_norm = {pg_out, gp_ttl_set, wd_pin};

    // fault states override outputs once forced
    logic [vio_pkg::N_TTL_OUT-1:0] ttl_o_r, ttl_oe_r;
    logic [vio_pkg::N_ISO_OUT-1:0] iso_o_r;
    for (genvar t = 0; t < vio_pkg::N_TTL_OUT; t++) begin : g_ttl
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                ttl_o_r[t]  <= 1'b0;
                ttl_oe_r[t] <= 1'b1;
            end else if (force_r) begin
                ttl_o_r[t]  <= (fs_ttl[t] == vio_pkg::VIO_FS_HIGH);
                ttl_oe_r[t] <= (fs_ttl[t] != vio_pkg::VIO_FS_HIZ);
            end else begin
                ttl_o_r[t]  <= ttl_norm[t];
                ttl_oe_r[t] <= 1'b1;
            end
        end
    end

    // isolated outputs: software or fault state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            iso_o_r <= '0;
        end else begin
            iso_o_r <= force_r ? fs_iso : gp_iso_set;
        end
    end

    assign ttl_out = ttl_o_r;
    assign ttl_oe  = ttl_oe_r;
    assign iso_out = iso_o_r;
endmodule
`default_nettype wire

/* sim/vio_field.sv */
`default_nettype none
module vio_field (
    // clock
    input  wire logic clk_sys,
    // encoder phases to iso six and seven
    output var logic  enc_a,
    output var logic  enc_b
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned EDGE_CYC = 250; // fastest spacing, 400k edges/s
    logic [1:0] ph_r = 2'h0; // quadrature phase index
    initial enc_a = 1'b0;
    initial enc_b = 1'b0;
    // one phase edge per step; a leads b going up
    task automatic step(input logic up, input int n);
        repeat (n) begin
            repeat (EDGE_CYC) @(posedge clk_sys);
            ph_r = up ? ph_r + 2'h1 : ph_r - 2'h1;
            enc_a <= ph_r[1] ^ ph_r[0];
            enc_b <= ph_r[1];
        end
    endtask
endmodule
`default_nettype wire

/* sim/vio_top_properties.sv */
`default_nettype none
module vio_props (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    // watched inputs
    input  wire vio_pkg::vio_wd_cfg_s wd_cfg,
    input  wire logic [3:0]           fs_iso,
    input  wire logic                 safe_sw,
    // watched outputs
    input  wire logic [9:0]           ttl_out,
    input  wire logic [9:0]           ttl_oe,
    input  wire logic [3:0]           iso_out,
    input  wire logic                 wd_expired,
    input  wire logic                 halted,
    input  wire logic                 power_fault,
    input  wire logic                 outputs_forced,
    input  wire logic                 sys_reset_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // expired watchdog in ttl action
    sequence s_wd_ttl_exp;
        wd_expired && wd_cfg.arm && wd_cfg.act == vio_pkg::VIO_WD_TTL;
    endsequence
    // safe switch held past the synchroniser
    sequence s_safe_held;
        safe_sw [*8];
    endsequence
    a_power_tracks_halt: assert property (power_fault == halted) else $error("power vs halt");
    a_halt_stays_set: assert property (halted |=> halted) else $error("halt cleared");
    a_force_stays_set: assert property (outputs_forced |=> outputs_forced) else $error("force cleared");
    a_force_needs_halt: assert property (outputs_forced |-> halted) else $error("force without halt");
    a_hiz_only_forced: assert property (!(&ttl_oe) |-> outputs_forced) else $error("hiz outside fault");
    a_fault_iso_state: assert property (outputs_forced |=> iso_out == $past(fs_iso)) else $error("iso state");
    a_wd_flag_holds: assert property (wd_expired && wd_cfg.arm |=> wd_expired) else $error("expiry lost");
    a_wd_ttl_drive: assert property (s_wd_ttl_exp |=> ttl_out[0] || outputs_forced) else $error("wd ttl low");
    a_safe_no_force: assert property (s_safe_held |-> !$rose(outputs_forced)) else $error("safe forced");
    a_reset_req_pulse: assert property (sys_reset_req |=> !sys_reset_req) else $error("long reset req");
endmodule
bind vio_top vio_props u_props (.clk_sys, .resetn, .wd_cfg, .fs_iso, .safe_sw,
    .ttl_out, .ttl_oe, .iso_out, .wd_expired, .halted, .power_fault, .outputs_forced, .sys_reset_req);
`default_nettype wire

/* sim/vision_io_pulse_fault_unit_test.sv */
`default_nettype none
module vision_io_pulse_fault_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned MSC = 20;          // short millisecond
    localparam logic [31:0] W10 = 32'h0000000A; // ten microseconds
    logic        clk_sys = 1'b0, resetn = 1'b0, safe_sw = 1'b0, overheat = 1'b0, reset_btn = 1'b0;
    logic [11:0] iso_r = 12'h800;              // shutdown pin high
    logic [1:0]  ttl_in = 2'h0;
    logic        shdn_en_cfg = 1'b0, psel_latch_en = 1'b0;
    logic [2:0]  gp_ttl_set = 3'h0;
    logic [3:0]  gp_iso_set = 4'h0;
    logic [3:0]  fs_iso = 4'h6;
    logic [9:0]  ttl_out, ttl_oe;
    logic [3:0]  iso_out;
    logic [31:0] enc_count;
    logic [4:0]  psel_value;
    logic [1:0]  gp_in;
    logic        wd_expired, halted, power_fault, outputs_forced, sys_reset_req, enc_a, enc_b;
    vio_pkg::vio_pg_cfg_s [5:0] pg_cfg;
    vio_pkg::vio_wd_cfg_s       wd_cfg;
    vio_pkg::vio_fs_e [9:0]     fs_ttl;
    int          miscompares = 0, checks = 0, d, w, k;
    always #5 clk_sys = ~clk_sys;
    vio_top #(.MS_CYC(MSC)) u_dut (.clk_sys, .resetn, .iso_in({iso_r[11:8], enc_b, enc_a, iso_r[5:0]}),
        .ttl_in, .safe_sw, .overheat, .reset_btn, .pg_cfg, .wd_cfg, .shdn_en_cfg, .psel_latch_en,
        .gp_ttl_set, .gp_iso_set, .fs_ttl, .fs_iso, .ttl_out, .ttl_oe, .iso_out, .enc_count,
        .psel_value, .gp_in, .wd_expired, .halted, .power_fault, .outputs_forced, .sys_reset_req);
    vio_field u_fld (.clk_sys, .enc_a, .enc_b);
    // generator setting in field order
    function automatic vio_pkg::vio_pg_cfg_s mk(logic r, vio_pkg::vio_trig_e t, logic f, h, e, logic [31:0] dl, wd);
        return {r, t, f, h, e, dl, wd};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic rst;
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
    endtask
    // cycles to reach level a, then cycles held
    task automatic meas(input int i, input logic a, output int dc, wc);
        dc = 0;
        wc = 0;
        while (ttl_out[i] !== a && dc < 3000) begin @(negedge clk_sys); dc++; end
        while (ttl_out[i] === a && wc < 3000) begin @(negedge clk_sys); wc++; end
        if (dc >= 3000 || wc >= 3000) begin
            miscompares++;
            end_sim;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 10; i++) fs_ttl[i] = vio_pkg::VIO_FS_LOW;
        fs_ttl[1] = vio_pkg::VIO_FS_HIGH;
        fs_ttl[2] = vio_pkg::VIO_FS_HIZ;
        pg_cfg = '0;
        wd_cfg = '0;
        rst;
        // two generators, one trigger, opposite edges
        pg_cfg[0] <= mk(1'b1, vio_pkg::VIO_TRIG_ISO8, 1'b0, 1'b1, 1'b0, W10, W10);
        pg_cfg[1] <= mk(1'b1, vio_pkg::VIO_TRIG_ISO8, 1'b1, 1'b0, 1'b0, W10, W10);
        cyc(5);
        iso_r[8] <= 1'b1;
        meas(4, 1'b1, d, w);
        chk("pg0 delay", 1, d > 990 && d < 1020);
        chk("pg0 width", 1000, w);
        chk("pg1 on rise", 1, ttl_out[5]);
        cyc(1);
        pg_cfg[0].width <= 32'h00000014;
        iso_r[8] <= 1'b0;
        meas(5, 1'b0, d, w);
        chk("pg1 width", 1000, w);
        chk("pg0 on fall", 0, ttl_out[4]);
        cyc(1);
        iso_r[8] <= 1'b1;
        meas(4, 1'b1, d, w);
        chk("pg0 rearm", 1000, w);
        // encoder timebase and quadrature count
        cyc(1);
        pg_cfg[2] <= mk(1'b1, vio_pkg::VIO_TRIG_IMM, 1'b0, 1'b1, 1'b1, 32'h2, W10);
        u_fld.step(1'b1, 1);
        chk("enc pending", 0, ttl_out[6]);
        u_fld.step(1'b1, 1);
        meas(6, 1'b1, d, w);
        chk("enc delay", 1, d < 20);
        chk("enc width", 1000, w);
        u_fld.step(1'b1, 6);
        cyc(8);
        chk("enc up", 8, enc_count);
        u_fld.step(1'b0, 4);
        cyc(8);
        chk("enc down", 4, enc_count);
        // product select, live then latched
        iso_r[4:0] <= 5'h15;
        cyc(8);
        chk("psel live", 5'h15, psel_value);
        psel_latch_en <= 1'b1;
        iso_r[5] <= 1'b1;
        cyc(8);
        iso_r[5] <= 1'b0;
        iso_r[4:0] <= 5'h0A;
        cyc(8);
        chk("psel held", 5'h15, psel_value);
        iso_r[5] <= 1'b1;
        cyc(8);
        chk("psel latch", 5'h0A, psel_value);
        // general-purpose pins
        iso_r[10:9] <= 2'h2;
        gp_ttl_set <= 3'h5;
        gp_iso_set <= 4'h9;
        cyc(8);
        chk("gp in", 2'h2, gp_in);
        chk("gp ttl", 3'h5, ttl_out[3:1]);
        chk("gp iso", 4'h9, iso_out);
        chk("gp trig", 0, ttl_out[4]);
        // watchdog ttl action: kick, expiry, disarm
        wd_cfg <= {1'b1, 1'b0, vio_pkg::VIO_WD_TTL, 16'h0003};
        cyc(30);
        wd_cfg.kick <= 1'b1;
        cyc(1);
        wd_cfg.kick <= 1'b0;
        cyc(35);
        chk("wd kick", 0, wd_expired);
        k = 0;
        while (wd_expired !== 1'b1 && k < 100) begin @(negedge clk_sys); k++; end
        chk("wd timeout", 1, k + 35 > 40 && k + 35 < 64);
        cyc(4);
        chk("wd flag", 1, wd_expired);
        chk("wd high", 1, ttl_out[0]);
        wd_cfg.arm <= 1'b0;
        cyc(3);
        chk("wd disarm", 0, wd_expired);
        chk("wd low", 0, ttl_out[0]);
        // external shutdown, disabled then enabled
        iso_r[11] <= 1'b0;
        cyc(10);
        chk("ext off", 0, halted);
        iso_r[11] <= 1'b1;
        shdn_en_cfg <= 1'b1;
        cyc(10);
        iso_r[11] <= 1'b0;
        cyc(10);
        chk("ext halt", 1, halted);
        chk("power", 1, power_fault);
        chk("forced", 1, outputs_forced);
        chk("fs iso", 4'h6, iso_out);
        chk("fs high", 1, ttl_out[1]);
        chk("fs low", 0, ttl_out[3]);
        chk("fs hiz", 0, ttl_oe[2]);
        iso_r[11] <= 1'b1;
        cyc(10);
        chk("sticky", 1, halted);
        // overheat in safe mode, shutdown set
        safe_sw <= 1'b1;
        rst;
        overheat <= 1'b1;
        cyc(10);
        chk("heat halt", 1, halted);
        chk("safe force", 0, outputs_forced);
        overheat <= 1'b0;
        safe_sw <= 1'b0;
        shdn_en_cfg <= 1'b0;
        rst;
        // watchdog shutdown action, shutdown off
        wd_cfg <= {1'b1, 1'b0, vio_pkg::VIO_WD_SHDN, 16'h0000};
        cyc(50);
        chk("wd halt", 1, halted);
        chk("wd force", 0, outputs_forced);
        wd_cfg.arm <= 1'b0;
        rst;
        // front-panel button held two seconds
        reset_btn <= 1'b1;
        k = 0;
        while (sys_reset_req !== 1'b1 && k < 45000) begin @(negedge clk_sys); k++; end
        chk("button", 1, k > 39800 && k < 40100);
        end_sim;
    end
endmodule
`default_nettype wire
